// ---- core/lcd_pkg.sv ----
// shared constants and types for the command decoder
package lcd_pkg;
  localparam int BANK_W     = 2;
  localparam int ADDR_W     = 13;
  localparam int AP_BIT     = 10;
  localparam int NBANKS     = 4;
  localparam int MASK_W     = 2;
  localparam int CLK_MHZ    = 100;
  // delays in ns, cycles derived (least times round up)
  localparam int T_MODE_LOAD_NS = 20;
  localparam int T_REFRESH_NS   = 72;
  localparam int T_PRECHARGE_NS = 15;
  localparam int T_BURST_CYC    = 4;
  localparam int MODE_LOAD_CYC  = (T_MODE_LOAD_NS * CLK_MHZ + 999) / 1000;
  localparam int REFRESH_CYC    = (T_REFRESH_NS * CLK_MHZ + 999) / 1000;
  localparam int PRECHARGE_CYC  = (T_PRECHARGE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W          = 8;
  localparam logic [1:0] MR_STD = 2'h0;
  localparam logic [1:0] MR_EXT = 2'h2;
  localparam logic [1:0] MR_STS = 2'h1;
  typedef enum logic [3:0] {
    LCD_CMD_IDLE, LCD_CMD_ACT, LCD_CMD_RD, LCD_CMD_WR, LCD_CMD_PRE, LCD_CMD_BST,
    LCD_CMD_DPD, LCD_CMD_AREF, LCD_CMD_SREF, LCD_CMD_MRS
  } lcd_cmd_t;
  typedef enum logic [1:0] {LCD_RUN, LCD_SELF_REF, LCD_DEEP_PD} lcd_mode_t;
endpackage

// ---- core/lcd_decoder.sv ----
// lpddr command decoder with bank, burst, refresh and power state
`timescale 1ns/1ps
module lcd_decoder
#(
  parameter int ROW_W = lcd_pkg::ADDR_W
)
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          cke,
  input  wire logic                          cs_n,
  input  wire logic                          ras_n,
  input  wire logic                          cas_n,
  input  wire logic                          we_n,
  input  wire logic [lcd_pkg::BANK_W-1:0]    bank_select,
  input  wire logic [lcd_pkg::ADDR_W-1:0]    addr,
  input  wire logic [lcd_pkg::MASK_W-1:0]    write_byte_mask,
  output logic [lcd_pkg::NBANKS-1:0]         bank_open,
  output logic [lcd_pkg::NBANKS*lcd_pkg::ADDR_W-1:0] open_rows,
  output logic                               rd_burst,
  output logic                               wr_burst,
  output logic [lcd_pkg::BANK_W-1:0]         burst_bank,
  output logic [lcd_pkg::ADDR_W-1:0]         burst_col,
  output logic                               burst_ap,
  output logic [lcd_pkg::MASK_W-1:0]         byte_write_en,
  output logic [lcd_pkg::ADDR_W-1:0]         refresh_row,
  output logic                               refresh_busy,
  output logic                               mode_busy,
  output logic [lcd_pkg::ADDR_W-1:0]         std_mode,
  output logic [lcd_pkg::ADDR_W-1:0]         ext_mode,
  output logic [lcd_pkg::ADDR_W-1:0]         status_reg,
  output logic                               self_refresh,
  output logic                               deep_power_down,
  output logic                               array_valid
);
  import lcd_pkg::*;

  // pins from outside pass two flops
  logic [4+BANK_W+ADDR_W+MASK_W:0] pin_s1;
  logic [4+BANK_W+ADDR_W+MASK_W:0] pin_s2;
  logic [CNT_W-1:0]  burst_cnt;
  logic [CNT_W-1:0]  busy_cnt;
  logic [CNT_W-1:0]  next_busy_cnt;
  lcd_mode_t         mode;

  always_ff @(posedge clk)
    if (rst)
    begin
      pin_s1 <= {1'b0, 4'hF, {(BANK_W+ADDR_W+MASK_W){1'b0}}};
      pin_s2 <= {1'b0, 4'hF, {(BANK_W+ADDR_W+MASK_W){1'b0}}};
    end
    else
    begin
      pin_s1 <= {cke, cs_n, ras_n, cas_n, we_n, bank_select, addr, write_byte_mask};
      pin_s2 <= pin_s1;
    end

  wire                s_cke  = pin_s2[4+BANK_W+ADDR_W+MASK_W];
  wire                s_cs_n = pin_s2[3+BANK_W+ADDR_W+MASK_W];
  wire                s_ras  = pin_s2[2+BANK_W+ADDR_W+MASK_W];
  wire                s_cas  = pin_s2[1+BANK_W+ADDR_W+MASK_W];
  wire                s_we   = pin_s2[BANK_W+ADDR_W+MASK_W];
  wire [BANK_W-1:0]   s_ba   = pin_s2[BANK_W+ADDR_W+MASK_W-1:ADDR_W+MASK_W];
  wire [ADDR_W-1:0]   s_a    = pin_s2[ADDR_W+MASK_W-1:MASK_W];
  wire [MASK_W-1:0]   s_dm   = pin_s2[MASK_W-1:0];
  wire                s_ap   = s_a[AP_BIT];

  function automatic lcd_cmd_t decode(input logic ck, input logic cs, input logic r,
                                      input logic c, input logic w);
    if (cs)
      decode = LCD_CMD_IDLE;
    else
      case ({r, c, w})
        3'h7: decode = LCD_CMD_IDLE;
        3'h3: decode = LCD_CMD_ACT;
        3'h5: decode = LCD_CMD_RD;
        3'h4: decode = LCD_CMD_WR;
        3'h2: decode = LCD_CMD_PRE;
        3'h6: decode = ck ? LCD_CMD_BST : LCD_CMD_DPD;
        3'h1: decode = ck ? LCD_CMD_AREF : LCD_CMD_SREF;
        3'h0: decode = LCD_CMD_MRS;
        default: decode = LCD_CMD_IDLE;
      endcase
  endfunction

  // only cke counts outside run mode
  wire       running = (mode == LCD_RUN);
  lcd_cmd_t  cmd;
  assign cmd = running ? decode(s_cke, s_cs_n, s_ras, s_cas, s_we) : LCD_CMD_IDLE;
  wire       is_act  = (cmd == LCD_CMD_ACT);
  wire       is_rd   = (cmd == LCD_CMD_RD);
  wire       is_wr   = (cmd == LCD_CMD_WR);
  wire       is_col  = is_rd | is_wr;
  wire       is_pre  = (cmd == LCD_CMD_PRE);
  wire       is_bst  = (cmd == LCD_CMD_BST) & rd_burst & ~burst_ap;
  wire       is_aref = (cmd == LCD_CMD_AREF);
  wire       is_mrs  = (cmd == LCD_CMD_MRS);
  wire       burst_done = (rd_burst | wr_burst) & (burst_cnt == CNT_W'(1));
  wire [NBANKS-1:0] ba_hot = NBANKS'(1) << s_ba;
  wire [NBANKS-1:0] burst_hot = NBANKS'(1) << burst_bank;
  wire [NBANKS-1:0] pre_mask = is_pre ? (s_ap ? {NBANKS{1'b1}} : ba_hot) : '0;
  wire [NBANKS-1:0] ap_mask = (burst_done & burst_ap) ? burst_hot : '0;
  wire [NBANKS-1:0] close_mask = pre_mask | ap_mask | ((is_mrs | is_aref) ? '1 : '0);

  assign next_busy_cnt = is_aref ? CNT_W'(REFRESH_CYC) :
                         is_mrs  ? CNT_W'(MODE_LOAD_CYC) :
                         (busy_cnt != '0) ? busy_cnt - CNT_W'(1) : busy_cnt;

  always_ff @(posedge clk)
    if (rst)
      bank_open <= '0;
    else if (mode == LCD_DEEP_PD)
      bank_open <= '0;
    else
      bank_open <= (bank_open & ~close_mask) | (is_act ? ba_hot : '0);

  genvar gb;
  for (gb = 0; gb < NBANKS; gb++)
  begin : g_row
    always_ff @(posedge clk)
      if (rst)
        open_rows[gb*ADDR_W +: ADDR_W] <= '0;
      else if (is_act && s_ba == BANK_W'(gb))
        open_rows[gb*ADDR_W +: ADDR_W] <= s_a;
  end

  always_ff @(posedge clk)
    if (rst)
    begin
      rd_burst   <= 1'b0;
      wr_burst   <= 1'b0;
      burst_cnt  <= '0;
      burst_bank <= '0;
      burst_col  <= '0;
      burst_ap   <= 1'b0;
    end
    else if (is_col)
    begin
      rd_burst   <= is_rd;
      wr_burst   <= is_wr;
      burst_cnt  <= CNT_W'(T_BURST_CYC);
      burst_bank <= s_ba;
      burst_col  <= s_a;
      burst_ap   <= s_ap;
    end
    else if (is_bst || burst_done || is_pre)
    begin
      rd_burst  <= 1'b0;
      wr_burst  <= 1'b0;
      burst_cnt <= '0;
    end
    else if (rd_burst || wr_burst)
      burst_cnt <= burst_cnt - CNT_W'(1);

  always_ff @(posedge clk)
    if (rst)
      byte_write_en <= '0;
    else
      byte_write_en <= wr_burst ? ~s_dm : '0;

  always_ff @(posedge clk)
    if (rst)
    begin
      refresh_row  <= '0;
      busy_cnt     <= '0;
      refresh_busy <= 1'b0;
      mode_busy    <= 1'b0;
    end
    else
    begin
      if (is_aref)
        refresh_row <= refresh_row + ADDR_W'(1);
      busy_cnt     <= next_busy_cnt;
      refresh_busy <= is_aref | (refresh_busy & (next_busy_cnt != '0));
      mode_busy    <= is_mrs | (mode_busy & (next_busy_cnt != '0));
    end

  always_ff @(posedge clk)
    if (rst)
    begin
      std_mode   <= '0;
      ext_mode   <= '0;
      status_reg <= '0;
    end
    else if (is_mrs)
      case (s_ba)
        MR_STD:  std_mode   <= s_a;
        MR_EXT:  ext_mode   <= s_a;
        MR_STS:  status_reg <= s_a;
        default: std_mode   <= std_mode;
      endcase

  // power modes by cke; array lost in deep power-down only
  lcd_mode_t         next_mode;
  always_comb
  begin
    next_mode = mode;
    case (mode)
      LCD_RUN:
        if (cmd == LCD_CMD_SREF)
          next_mode = LCD_SELF_REF;
        else if (cmd == LCD_CMD_DPD)
          next_mode = LCD_DEEP_PD;
      LCD_SELF_REF, LCD_DEEP_PD:
        if (s_cke)
          next_mode = LCD_RUN;
      default:
        next_mode = LCD_RUN;
    endcase
  end
  always_ff @(posedge clk)
    if (rst)
    begin
      mode            <= LCD_RUN;
      self_refresh    <= 1'b0;
      deep_power_down <= 1'b0;
      array_valid     <= 1'b1;
    end
    else
    begin
      mode            <= next_mode;
      self_refresh    <= (next_mode == LCD_SELF_REF);
      deep_power_down <= (next_mode == LCD_DEEP_PD);
      array_valid     <= array_valid & (cmd != LCD_CMD_DPD);
    end

  a_deselect_quiet: assert property (@(posedge clk) disable iff (rst)
    (running && s_cs_n) |=> $stable(bank_open) || (bank_open == ($past(bank_open) & ~$past(ap_mask))))
    else $error("deselect changed bank state");
  a_nop_quiet: assert property (@(posedge clk) disable iff (rst)
    (running && !s_cs_n && s_ras && s_cas && s_we && !rd_burst && !wr_burst) |=> $stable(bank_open))
    else $error("idle command changed banks");
  a_act_opens: assert property (@(posedge clk) disable iff (rst)
    is_act |=> (bank_open[$past(s_ba)] && open_rows[$past(s_ba)*ADDR_W +: ADDR_W] == $past(s_a)))
    else $error("activate did not open row");
  a_read_start: assert property (@(posedge clk) disable iff (rst)
    is_rd |=> rd_burst && !wr_burst && burst_col == $past(s_a))
    else $error("read burst not started");
  a_ap_latch: assert property (@(posedge clk) disable iff (rst)
    is_col |=> burst_ap == $past(s_ap))
    else $error("auto precharge not latched");
  a_pre_all: assert property (@(posedge clk) disable iff (rst)
    (is_pre && s_ap && !is_act) |=> bank_open == '0)
    else $error("precharge all left a bank open");
  a_dpd_entry: assert property (@(posedge clk) disable iff (rst)
    (cmd == LCD_CMD_DPD) |=> deep_power_down && !array_valid)
    else $error("deep power-down not entered");
  a_sref_entry: assert property (@(posedge clk) disable iff (rst)
    (cmd == LCD_CMD_SREF) |=> self_refresh)
    else $error("self refresh not entered");
  a_mask_byte: assert property (@(posedge clk) disable iff (rst)
    wr_burst |=> byte_write_en == ~$past(s_dm))
    else $error("byte mask not applied");
  a_bst_trunc: assert property (@(posedge clk) disable iff (rst)
    is_bst |=> !rd_burst && $stable(bank_open))
    else $error("terminate mishandled");
  a_refresh_len: assert property (@(posedge clk) disable iff (rst)
    is_aref |=> refresh_busy [*8] ##1 !refresh_busy)
    else $error("refresh time wrong");
  c_read: cover property (@(posedge clk) is_act ##[1:10] is_rd);
  c_write_ap: cover property (@(posedge clk) is_wr && s_ap);
  c_sref: cover property (@(posedge clk) self_refresh ##1 !self_refresh);
  c_bst: cover property (@(posedge clk) is_bst);
endmodule

// ---- test/lcd_ctrl_model.sv ----
// controller model: command codes to pins
`timescale 1ns/1ps
module lcd_ctrl_model
(
  input  wire lcd_pkg::lcd_cmd_t cmd,
  input  wire logic              desel,
  input  wire logic              cke_in,
  output logic                   cke,
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n
);
  import lcd_pkg::*;
  logic [2:0] code;
  assign cke = cke_in;
  assign cs_n = desel;
  assign {ras_n, cas_n, we_n} = code;
  always_comb
  begin
    case (cmd)
      LCD_CMD_ACT: code = 3'h3;
      LCD_CMD_RD: code = 3'h5;
      LCD_CMD_WR: code = 3'h4;
      LCD_CMD_PRE: code = 3'h2;
      LCD_CMD_BST, LCD_CMD_DPD: code = 3'h6;
      LCD_CMD_AREF, LCD_CMD_SREF: code = 3'h1;
      LCD_CMD_MRS: code = 3'h0;
      default: code = 3'h7;
    endcase
  end
endmodule

// ---- test/lpddr_command_decoder_tb.sv ----
// testbench for the command decoder
`timescale 1ns/1ps
module lpddr_command_decoder_tb;
  import lcd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lcd_cmd_t cmd = LCD_CMD_IDLE;
  logic desel = 1'b0;
  logic cke_in = 1'b1;
  logic [1:0] bank_select = 2'h0;
  logic [12:0] addr = 13'h0000;
  logic [1:0] mask = 2'h0;
  logic cke, cs_n, ras_n, cas_n, we_n, rd_burst, wr_burst, burst_ap;
  logic refresh_busy, mode_busy, self_refresh, deep_power_down, array_valid;
  logic [3:0] bank_open;
  logic [51:0] open_rows;
  logic [1:0] burst_bank, byte_write_en;
  logic [12:0] burst_col, refresh_row, std_mode, ext_mode, status_reg;
  int num_errors = 0;
  int cmp_count = 0;

  lcd_ctrl_model i_ctrl (.cmd(cmd), .desel(desel), .cke_in(cke_in), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));
  lcd_decoder i_dut (.clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_select(bank_select), .addr(addr), .write_byte_mask(mask),
    .bank_open(bank_open), .open_rows(open_rows), .rd_burst(rd_burst), .wr_burst(wr_burst),
    .burst_bank(burst_bank), .burst_col(burst_col), .burst_ap(burst_ap),
    .byte_write_en(byte_write_en), .refresh_row(refresh_row), .refresh_busy(refresh_busy),
    .mode_busy(mode_busy), .std_mode(std_mode), .ext_mode(ext_mode), .status_reg(status_reg),
    .self_refresh(self_refresh), .deep_power_down(deep_power_down), .array_valid(array_valid));

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic nops(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one command edge, then idle until its outputs settle
  task automatic go(input lcd_cmd_t c, input logic [1:0] b, input logic [12:0] a);
    @(posedge clk);
    cmd <= c;
    bank_select <= b;
    addr <= a;
    @(posedge clk);
    cmd <= LCD_CMD_IDLE;
    nops(3);
  endtask

  task automatic t_desel();
    @(posedge clk);
    desel <= 1'b1;
    go(LCD_CMD_MRS, 2'h0, 13'h01AB);
    go(LCD_CMD_ACT, 2'h0, 13'h0011);
    chk("std_mode", 0, std_mode);
    chk("bank_open", 0, bank_open);
    @(posedge clk);
    desel <= 1'b0;
    $display("test desel done");
  endtask

  task automatic t_read();
    go(LCD_CMD_ACT, 2'h1, 13'h0ABC);
    chk("bank_open", 4'h2, bank_open);
    chk("row1", 13'h0ABC, open_rows[13+:13]);
    go(LCD_CMD_RD, 2'h1, 13'h0005);
    chk("rd_burst", 1, rd_burst);
    chk("burst_bank", 2'h1, burst_bank);
    chk("burst_col", 13'h0005, burst_col);
    chk("burst_ap", 0, burst_ap);
    nops(2);
    chk("rd_burst", 1, rd_burst);
    nops(1);
    chk("rd_burst", 0, rd_burst);
    chk("bank_open", 4'h2, bank_open);
    // terminate lands while the read still runs
    @(posedge clk);
    cmd <= LCD_CMD_RD;
    bank_select <= 2'h1;
    addr <= 13'h0007;
    @(posedge clk);
    cmd <= LCD_CMD_BST;
    @(posedge clk);
    cmd <= LCD_CMD_IDLE;
    nops(3);
    chk("burst_col", 13'h0007, burst_col);
    chk("rd_burst", 0, rd_burst);
    chk("bank_open", 4'h2, bank_open);
    chk("deep_pd", 0, deep_power_down);
    $display("test read done");
  endtask

  task automatic t_write();
    mask <= 2'h1;
    go(LCD_CMD_WR, 2'h1, 13'h0403);
    chk("wr_burst", 1, wr_burst);
    chk("burst_ap", 1, burst_ap);
    nops(1);
    chk("byte_write_en", 2'h2, byte_write_en);
    nops(3);
    chk("wr_burst", 0, wr_burst);
    chk("bank_open", 0, bank_open);
    mask <= 2'h0;
    $display("test write done");
  endtask

  task automatic t_pre();
    go(LCD_CMD_ACT, 2'h1, 13'h0001);
    go(LCD_CMD_ACT, 2'h2, 13'h0111);
    go(LCD_CMD_PRE, 2'h1, 13'h0000);
    chk("bank_open", 4'h4, bank_open);
    nops(PRECHARGE_CYC);
    go(LCD_CMD_PRE, 2'h1, 13'h0400);
    chk("bank_open", 0, bank_open);
    nops(PRECHARGE_CYC);
    $display("test precharge done");
  endtask

  task automatic t_mode();
    logic [1:0] sel [3] = '{MR_STD, MR_EXT, MR_STS};
    for (int i = 0; i < 3; i++)
    begin
      go(LCD_CMD_MRS, sel[i], 13'h0100 + 13'(i));
      chk("mode_busy", 1, mode_busy);
      nops(MODE_LOAD_CYC);
      chk("mode_busy", 0, mode_busy);
    end
    chk("std_mode", 13'h0100, std_mode);
    chk("ext_mode", 13'h0101, ext_mode);
    chk("status_reg", 13'h0102, status_reg);
    $display("test mode done");
  endtask

  task automatic t_aref();
    logic [12:0] r;
    r = refresh_row;
    go(LCD_CMD_AREF, 2'h3, 13'h1FFF);
    chk("refresh_busy", 1, refresh_busy);
    chk("refresh_row", r + 13'h0001, refresh_row);
    chk("self_refresh", 0, self_refresh);
    nops(REFRESH_CYC - 2);
    chk("refresh_busy", 1, refresh_busy);
    nops(1);
    chk("refresh_busy", 0, refresh_busy);
    $display("test refresh done");
  endtask

  task automatic t_power(input lcd_cmd_t c);
    @(posedge clk);
    cke_in <= 1'b0;
    go(c, 2'h0, 13'h0000);
    chk("self_refresh", c == LCD_CMD_SREF, self_refresh);
    chk("deep_pd", c == LCD_CMD_DPD, deep_power_down);
    chk("array_valid", c != LCD_CMD_DPD, array_valid);
    go(LCD_CMD_ACT, 2'h3, 13'h0042);
    chk("bank_open", 0, bank_open);
    @(posedge clk);
    cke_in <= 1'b1;
    nops(4);
    chk("power_mode", 0, {self_refresh, deep_power_down});
    $display("test power %s done", c.name());
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    nops(1);
    chk("array_valid", 1, array_valid);
    t_desel();
    t_read();
    t_write();
    t_pre();
    t_mode();
    t_aref();
    t_power(LCD_CMD_SREF);
    t_power(LCD_CMD_DPD);
    report_and_stop();
  end
endmodule
